// ==== hdl/fpc_param_overlay.sv ====
`timescale 1ns/100ps
// Function
// [R1] source address register holds all 32 bits of the data start address
// [R2] source address inside flash sets the source data error flag
// [R3] one program request moves 128 bytes from the source start address
// [R4] small variant accepts erase blocks 0 to 13
// [R5] large variant accepts erase blocks 0 to 15
// [R6] erase block value n selects block n
// [R7] block number above the variant limit flags error, no erase issued
// [R8] when enabled, RAM window ffa000-ffafff overlays the selected flash block
// [R9] software should write emulation control only in user or user program mode
// [R10] software must not touch emulated area right after control write
// [R11] emulation select clear disables overlay, reads come from flash array
// [R12] emulation select set enables overlay and protects all blocks
// [R13] three-bit area select chooses the overlaid block, only while enabled
// [R14] area code k maps overlay to k*1000 through k*1000+fff
// [R15] control bits 7 to 4 read zero and ignore writes
// [R16] read of selected block while overlaid returns RAM byte at same offset
// [R17] control register resets to zero: emulation off, block 0
module fpc_param_overlay #(
  parameter int FLASH_BYTES = 32'h00040000,
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // request towards the flash sequencer
  output fpc_pkg::fpc_flash_req_type flash_req_o,
  input wire logic flash_done_i,
  // status to the rest of the unit
  output logic src_data_err_o,
  output logic erase_range_err_o,
  output logic prog_erase_protect_o,
  // overlay address decode
  output logic [31:0] mapped_addr_o,
  output logic map_to_ram_o
);
  import fpc_pkg::*;
  typedef enum {FPC_IDLE, FPC_BUSY} fpc_state_type;
  logic [31:0] src_addr, next_src_addr;
  logic [31:0] erase_blk, next_erase_blk;
  logic [7:0] emu_ctrl, next_emu_ctrl;
  logic [31:0] probe_addr, next_probe_addr;
  logic src_err, next_src_err;
  logic range_err, next_range_err;
  fpc_state_type state, next_state;
  fpc_flash_req_type req, next_req;
  logic [31:0] map_addr, next_map_addr;
  logic map_ram, next_map_ram;
  // ready flags kept as flops so the bus outputs come straight from registers
  logic aw_free, next_aw_free;
  logic w_free, next_w_free;
  logic ar_free, next_ar_free;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic protect, next_protect;
  logic emu_on, do_write, src_in_flash, blk_bad;
  logic [15:0] last_blk;
  logic [31:0] wr_merged, ovl_base;

  assign emu_on = emu_ctrl[EMU_SEL_BIT];
  assign last_blk = LARGE_VARIANT ? LAST_BLK_LARGE : LAST_BLK_SMALL; // [R4] [R5]
  assign do_write = !aw_free && !w_free && !bvalid;
  // overlay base is area code times block size
  assign ovl_base = FLASH_BASE + {17'h00000, emu_ctrl[AREA_MSB:0], 12'h000}; // [R14]
  assign src_in_flash = (src_addr >= FLASH_BASE) &&
                        (src_addr - FLASH_BASE < 32'(FLASH_BYTES)); // [R2]
  assign blk_bad = (erase_blk > {16'h0000, last_blk}); // [R7]

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr_merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
    end
  end

  // bus handshake and register writes
  always_comb
  begin
    next_aw_free = aw_free;
    next_w_free = w_free;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_src_addr = src_addr;
    next_erase_blk = erase_blk;
    next_emu_ctrl = emu_ctrl;
    next_probe_addr = probe_addr;
    next_src_err = src_err;
    next_range_err = range_err;
    next_state = state;
    next_req = req;
    if (s_axi_awvalid_i && aw_free)
    begin
      next_aw_free = 1'b0;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && w_free)
    begin
      next_w_free = 1'b0;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i)
    begin
      next_bvalid = 1'b0;
    end
    if (state == FPC_BUSY && flash_done_i)
    begin
      next_state = FPC_IDLE;
      next_req.prog = 1'b0;
      next_req.erase = 1'b0;
    end
    if (do_write)
    begin
      next_aw_free = 1'b1;
      next_w_free = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        OFS_SRC_ADDR:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (w_strb[i])
            begin
              next_src_addr[i*8 +: 8] = w_data[i*8 +: 8]; // [R1]
            end
          end
        end
        OFS_ERASE_BLK:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (w_strb[i])
            begin
              next_erase_blk[i*8 +: 8] = w_data[i*8 +: 8];
            end
          end
        end
        OFS_EMU_CTRL:
          next_emu_ctrl = w_strb[0] ? (w_data[7:0] & EMU_CTRL_MASK) : emu_ctrl; // [R15]
        OFS_MAP_ADDR:
          next_probe_addr = wr_merged;
        OFS_CMD:
        begin
          if (state == FPC_IDLE && wr_merged[CMD_PROG_BIT])
          begin
            next_src_err = src_in_flash; // [R2]
            if (!src_in_flash && !emu_on) // [R12]
            begin
              next_req.prog = 1'b1; // [R3]
              next_req.src_addr = src_addr; // [R3]
              next_state = FPC_BUSY;
            end
          end
          else if (state == FPC_IDLE && wr_merged[CMD_ERASE_BIT])
          begin
            next_range_err = blk_bad; // [R7]
            if (!blk_bad && !emu_on) // [R7] [R12]
            begin
              next_req.erase = 1'b1;
              next_req.block = erase_blk[3:0]; // [R6]
              next_state = FPC_BUSY;
            end
          end
        end
        OFS_STATUS:
        begin
          next_src_err = src_err && !wr_merged[ST_SRC_ERR];
          next_range_err = range_err && !wr_merged[ST_ERASE_ERR];
        end
        default:
          next_bresp = RESP_SLVERR;
      endcase
    end
  end

  // read channel
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_i)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h00000000;
      case (s_axi_araddr_i)
        OFS_SRC_ADDR: next_rdata = src_addr;
        OFS_ERASE_BLK: next_rdata = erase_blk;
        OFS_EMU_CTRL: next_rdata = {24'h000000, emu_ctrl & EMU_CTRL_MASK}; // [R15]
        OFS_STATUS:
        begin
          next_rdata[ST_SRC_ERR] = src_err;
          next_rdata[ST_ERASE_ERR] = range_err;
          next_rdata[ST_PROTECT] = protect;
          next_rdata[ST_BUSY] = (state == FPC_BUSY);
          next_rdata[ST_MAP_RAM] = map_ram;
        end
        OFS_MAP_ADDR: next_rdata = probe_addr;
        OFS_MAP_RESULT: next_rdata = map_addr;
        OFS_CMD: next_rdata = 32'h00000000;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    next_ar_free = !next_rvalid;
  end

  // overlay decode of the probe address
  always_comb
  begin
    next_protect = emu_on; // [R12]
    next_map_ram = 1'b0;
    next_map_addr = probe_addr; // [R11]
    if (emu_on && probe_addr[31:BLOCK_BITS] == ovl_base[31:BLOCK_BITS]) // [R13] [R8]
    begin
      next_map_ram = 1'b1;
      next_map_addr = RAM_WIN_BASE | {20'h00000, probe_addr[BLOCK_BITS-1:0]}; // [R16]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_free <= 1'b1;
      w_free <= 1'b1;
      ar_free <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      src_addr <= 32'h00000000;
      erase_blk <= 32'h00000000;
      emu_ctrl <= EMU_CTRL_RST; // [R17]
      probe_addr <= 32'h00000000;
      src_err <= 1'b0;
      range_err <= 1'b0;
      state <= FPC_IDLE;
      req <= '0;
      map_addr <= 32'h00000000;
      map_ram <= 1'b0;
      protect <= 1'b0;
    end
    else
    begin
      aw_free <= next_aw_free;
      w_free <= next_w_free;
      ar_free <= next_ar_free;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      src_addr <= next_src_addr;
      erase_blk <= next_erase_blk;
      emu_ctrl <= next_emu_ctrl;
      probe_addr <= next_probe_addr;
      src_err <= next_src_err;
      range_err <= next_range_err;
      state <= next_state;
      req <= next_req;
      map_addr <= next_map_addr;
      map_ram <= next_map_ram;
      protect <= next_protect;
    end
  end

  assign s_axi_awready_o = aw_free;
  assign s_axi_wready_o = w_free;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = ar_free;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign flash_req_o = req;
  assign src_data_err_o = src_err;
  assign erase_range_err_o = range_err;
  assign prog_erase_protect_o = protect;
  assign mapped_addr_o = map_addr;
  assign map_to_ram_o = map_ram;

  property p_emu_blocks_req;
    @(posedge clk_i) disable iff (rst_i)
    emu_on |=> !($rose(req.prog) || $rose(req.erase));
  endproperty
  a_emu_blocks_req: assert property (p_emu_blocks_req) else $error("request issued while emulation on"); // [R12]
  property p_bad_blk_no_erase;
    @(posedge clk_i) disable iff (rst_i)
    $rose(req.erase) |-> (req.block <= last_blk[3:0]) && !range_err;
  endproperty
  a_bad_blk_no_erase: assert property (p_bad_blk_no_erase) else $error("erase of out of range block"); // [R7]
  property p_src_err_no_prog;
    @(posedge clk_i) disable iff (rst_i)
    $rose(req.prog) |-> !src_err;
  endproperty
  a_src_err_no_prog: assert property (p_src_err_no_prog) else $error("program with source error"); // [R2]
  property p_ctrl_high_zero;
    @(posedge clk_i) disable iff (rst_i)
    emu_ctrl[7:4] == 4'h0;
  endproperty
  a_ctrl_high_zero: assert property (p_ctrl_high_zero) else $error("control upper bits set"); // [R15]
  property p_protect_follows;
    @(posedge clk_i) disable iff (rst_i)
    emu_on |=> protect;
  endproperty
  a_protect_follows: assert property (p_protect_follows) else $error("protect not raised"); // [R12]
  property p_no_map_when_off;
    @(posedge clk_i) disable iff (rst_i)
    !emu_on ##1 !$past(emu_on) |-> !map_ram || $past(emu_on, 1);
  endproperty
  a_no_map_when_off: assert property (p_no_map_when_off) else $error("overlay active while disabled"); // [R11]
  property p_map_in_window;
    @(posedge clk_i) disable iff (rst_i)
    map_ram |-> (map_addr >= RAM_WIN_BASE) && (map_addr <= RAM_WIN_LAST);
  endproperty
  a_map_in_window: assert property (p_map_in_window) else $error("mapped address outside RAM window"); // [R8]
  property p_map_offset;
    @(posedge clk_i) disable iff (rst_i)
    map_ram |-> map_addr[BLOCK_BITS-1:0] == $past(probe_addr[BLOCK_BITS-1:0]);
  endproperty
  a_map_offset: assert property (p_map_offset) else $error("overlay offset mismatch"); // [R16]
endmodule

// ==== hdl/fpc_pkg.sv ====
package fpc_pkg;
  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_SRC_ADDR = 8'h00;
  localparam logic [7:0] OFS_ERASE_BLK = 8'h04;
  localparam logic [7:0] OFS_EMU_CTRL = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MAP_ADDR = 8'h14;
  localparam logic [7:0] OFS_MAP_RESULT = 8'h18;
  // control field layout
  localparam int EMU_SEL_BIT = 3;
  localparam int AREA_MSB = 2;
  localparam logic [7:0] EMU_CTRL_MASK = 8'h0f;
  localparam logic [7:0] EMU_CTRL_RST = 8'h00;
  // command bits
  localparam int CMD_PROG_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  // status bit positions
  localparam int ST_SRC_ERR = 0;
  localparam int ST_ERASE_ERR = 1;
  localparam int ST_PROTECT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_MAP_RAM = 4;
  // address windows
  localparam logic [31:0] RAM_WIN_BASE = 32'h00ffa000;
  localparam logic [31:0] RAM_WIN_LAST = 32'h00ffafff;
  localparam logic [31:0] FLASH_BASE = 32'h00000000;
  localparam int BLOCK_BITS = 12;
  localparam logic [15:0] LAST_BLK_SMALL = 16'h000d;
  localparam logic [15:0] LAST_BLK_LARGE = 16'h000f;
  localparam logic [7:0] PROG_BYTES = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic prog;
    logic erase;
    logic [31:0] src_addr;
    logic [3:0] block;
  } fpc_flash_req_type;
endpackage

// ==== verif/fpc_param_overlay_bench.sv ====
`timescale 1ns/100ps
module fpc_param_overlay_bench;
  import fpc_pkg::*;
  logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, done;
  logic awready, wready, bvalid, arready, rvalid, src_err, rng_err, prot, hit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mapped, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  fpc_flash_req_type req;
  int fail_count, n_compared, cycles;

  fpc_param_overlay uut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .flash_req_o(req),
    .flash_done_i(done), .src_data_err_o(src_err), .erase_range_err_o(rng_err),
    .prog_erase_protect_o(prot), .mapped_addr_o(mapped), .map_to_ram_o(hit));

  // small variant on the same bus, only its range flag is watched
  logic small_rng_err;
  fpc_param_overlay #(.LARGE_VARIANT(1'b0)) uut_small (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(), .s_axi_rdata_o(), .s_axi_rresp_o(),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready), .flash_req_o(), .flash_done_i(done), .src_data_err_o(),
    .erase_range_err_o(small_rng_err), .prog_erase_protect_o(), .mapped_addr_o(), .map_to_ram_o());

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; holds each channel until its handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk_i);
      if (!ad && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    // bready stays high so a following call only redrives it to the same value in the same step
    resp = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
    chk_word(rd, exp);
  endtask

  task automatic probe(input logic [31:0] a, input logic [31:0] exp, input logic exp_hit);
    wrc(OFS_MAP_ADDR, a);
    rdc(OFS_MAP_RESULT, exp);
    rd_reg(OFS_STATUS);
    chk_bit(rd[ST_MAP_RAM], exp_hit);
    chk_word(mapped, exp);
    chk_bit(hit, exp_hit);
  endtask

  task automatic finish_req();
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_bit(req.prog | req.erase, 1'b0);
  endtask

  initial
  begin
    logic [15:0] blks [5];
    logic ok;
    blks = '{16'h0000, 16'h000d, 16'h000f, 16'h0010, 16'hffff};
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, done} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFS_EMU_CTRL, 32'h0);
    rd_reg(8'h40);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk_word(rd, 32'h0);
    wrc(OFS_EMU_CTRL, 32'hff);
    rdc(OFS_EMU_CTRL, 32'h0f);
    chk_bit(prot, 1'b1);
    wrc(OFS_ERASE_BLK, 32'h3);
    wrc(OFS_CMD, 32'h2);
    repeat (2) @(posedge clk_i);
    chk_bit(req.erase, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      wrc(OFS_EMU_CTRL, 32'h8 | k);
      // one idle cycle before the overlaid area is looked at again
      @(posedge clk_i);
      probe(k * 32'h1000 + 32'h123, 32'h00ffa123, 1'b1);
      probe(k * 32'h1000 + 32'hfff, 32'h00ffafff, 1'b1);
      probe(((k + 1) % 8) * 32'h1000 + 32'h7fc, ((k + 1) % 8) * 32'h1000 + 32'h7fc, 1'b0);
    end
    wrc(OFS_EMU_CTRL, 32'h7);
    @(posedge clk_i);
    probe(32'h00007123, 32'h00007123, 1'b0);
    chk_bit(prot, 1'b0);
    wrc(OFS_SRC_ADDR, 32'h0003ff80);
    wrc(OFS_CMD, 32'h1);
    repeat (2) @(posedge clk_i);
    chk_bit(src_err, 1'b1);
    rd_reg(OFS_STATUS);
    chk_bit(rd[ST_SRC_ERR], 1'b1);
    wrc(OFS_STATUS, 32'h1);
    chk_bit(src_err, 1'b0);
    finish_req();
    wrc(OFS_SRC_ADDR, 32'h80ffa000);
    rdc(OFS_SRC_ADDR, 32'h80ffa000);
    wrc(OFS_CMD, 32'h1);
    repeat (2) @(posedge clk_i);
    chk_bit(src_err, 1'b0);
    chk_bit(req.prog, 1'b1);
    chk_word(req.src_addr, 32'h80ffa000);
    rd_reg(OFS_STATUS);
    chk_bit(rd[ST_BUSY], 1'b1);
    finish_req();
    for (int i = 0; i < 5; i++)
    begin
      ok = (blks[i] <= LAST_BLK_LARGE);
      wrc(OFS_ERASE_BLK, {16'h0, blks[i]});
      wrc(OFS_CMD, 32'h2);
      repeat (2) @(posedge clk_i);
      chk_bit(rng_err, !ok);
      chk_bit(small_rng_err, blks[i] > LAST_BLK_SMALL);
      chk_bit(req.erase, ok);
      if (ok)
        chk_word({28'h0, req.block}, {28'h0, blks[i][3:0]});
      finish_req();
    end
    summarize();
  end
endmodule
